// ### wcm_pkg.sv
// Constants and types shared by the windowed watchdog and its clock monitor
package wcm_pkg;

    // Service register field layout
    localparam int SEL_MSB = 7;
    localparam int SEL_LSB = 6;
    localparam int KEY_MSB = 5;
    localparam int KEY_LSB = 1;
    localparam int CMEN_BIT = 0;

    // Fixed key, reset values and window bounds in idle-timer clocks
    localparam logic [4:0]  KEY_VALUE   = 5'h0c;
    localparam logic [1:0]  SEL_RESET   = 2'h3;
    localparam logic        CMEN_RESET  = 1'h1;
    localparam logic [16:0] LOWER_BOUND = 17'h00800;
    localparam logic [16:0] UPPER_BASE  = 17'h02000;

    // Release delay after the pin is sensed low or the clock recovers
    localparam logic [4:0]  RELEASE_CYC = 5'h10;

    // Clock monitor rejection limit: time in microseconds and core clock rate
    localparam int CORE_CLK_MHZ = 20;
    localparam int CM_LIMIT_US  = 1000;
    localparam int CM_LIMIT_CYC = CM_LIMIT_US * CORE_CLK_MHZ;

    // Fault pin sequencer states
    typedef enum logic [1:0] {
        FLT_IDLE      = 2'b00,
        FLT_WAIT_LOW  = 2'b01,
        FLT_HOLD      = 2'b10,
        FLT_WAIT_HIGH = 2'b11
    } wcm_flt_t;

endpackage

// ### wcm_clk_mon.sv
// Clock monitor: flags a missing or too slow instruction clock
`timescale 1ns/1ns
`default_nettype none
module wcm_clk_mon #(
    parameter logic [15:0] CM_LIMIT = 16'h4e20
) (
    input  wire logic core_clk,
    input  wire logic nrst,
    input  wire logic instr_clk_in,
    input  wire logic mon_en,
    output var  logic cm_hold
);
    import wcm_pkg::*;

    typedef struct packed {
        logic        s1;
        logic        s2;
        logic        s3;
        logic [15:0] per;
        logic [4:0]  rel;
        logic        hold;
    } wcm_cm_st_t;

    wcm_cm_st_t st_r;
    wcm_cm_st_t st_nxt;

    // Period measure on agreed edges; stall at the limit so a dead clock stays flagged
    always_comb begin
        st_nxt    = st_r;
        st_nxt.s1 = instr_clk_in;
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
        if (st_r.s2 != st_r.s3) begin
            st_nxt.per = 16'h0000;
        end else if (st_r.per != CM_LIMIT) begin
            st_nxt.per = st_r.per + 16'h0001;
        end
        if (!mon_en) begin
            st_nxt.hold = 1'b0;
            st_nxt.rel  = 5'h00;
        end else if (st_r.per == CM_LIMIT) begin
            st_nxt.hold = 1'b1;
            st_nxt.rel  = 5'h00;
        end else if (st_r.hold) begin
            st_nxt.rel = st_r.rel + 5'h01;
            if (st_r.rel == RELEASE_CYC - 5'h01) begin
                st_nxt.hold = 1'b0;
            end
        end
    end

    // Detector idle while reset is held
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign cm_hold = st_r.hold;

    AST_CM_FLAG: assert property (@(posedge core_clk) disable iff (!nrst)
        mon_en && st_r.per == CM_LIMIT |=> cm_hold)
        else $error("clock monitor missed a stalled clock");

endmodule
`default_nettype wire

// ### wcm_watchdog.sv
// Windowed watchdog with clock monitor driving an open-drain fault pin
//
// Notes on behaviour
// - Service write holds window select 7:6, key 5:1, monitor enable bit 0.
// - The key must equal the fixed value on every service.
// - Lower bound is a fixed 2048 idle-timer clocks after window start.
// - Window select picks upper bound 8k, 16k, 32k or 64k clocks.
// - Window counts advance on idle-timer clock ticks.
// - Watchdog and clock monitor detectors are inactive during reset.
// - After reset the longest window and the clock monitor are selected.
// - Only the first keyed write after reset loads select and monitor enable.
// - Later writes matching all fields are valid services restarting the window.
// - A later write with any mismatching field raises a fault.
// - No valid service before the upper bound raises a fault.
// - A service before the lower bound raises a fault.
// - Boot ROM entry suppresses lower-bound errors and services immediately.
// - The watchdog works only when option bit 2 is zero.
// - Fault pin is active low, released to a weak pull-up.
// - On error pull low, hold 16 more cycles once sensed low, release.
// - The service window restarts when the pin returns high.
// - Service writes while the fault is active are ignored.
// - Clock monitor holds the pin low while slow, releasing after recovery.
// - Clocks above 5 kHz pass; below 10 Hz or dead are flagged.
// - A pin stuck low keeps the sequencer waiting for high; there is no timeout.
// - Reads return zero in the key field.
// - Watchdog halts in HALT and IDLE; clock monitor keeps running.
// - Leaving IDLE performs a hardware service.
`timescale 1ns/1ns
`default_nettype none
module wcm_watchdog #(
    parameter logic [15:0] CM_LIMIT = 16'h4e20
) (
    input  wire logic       core_clk,
    input  wire logic       nrst,
    input  wire logic       svc_wr,
    input  wire logic [7:0] svc_wdata,
    output var  logic [7:0] svc_rdata,
    input  wire logic       idle_tick,
    input  wire logic       wd_option_bit2,
    input  wire logic       halt_mode,
    input  wire logic       idle_mode,
    input  wire logic       boot_rom_active,
    input  wire logic       instr_clk_in,
    input  wire logic       fault_pin_in,
    output var  logic       fault_out_n,
    output var  logic       fault_oe
);
    import wcm_pkg::*;

    typedef struct packed {
        wcm_flt_t    flt;
        logic [1:0]  sel;
        logic        cm_en;
        logic        first_done;
        logic        lower_en;
        logic [16:0] cnt;
        logic [4:0]  hold_cnt;
        logic        started;
        logic        wd_en;
        logic        idle_d;
        logic        halt_d;
        logic        boot_d;
        logic        pin_s1;
        logic        pin_s2;
        logic        pin_s3;
        logic        pin_lvl;
        logic [7:0]  rdata;
        logic        drive;
        logic        out_n;
    } wcm_wd_st_t;

    wcm_wd_st_t st_r;
    wcm_wd_st_t st_nxt;

    logic        cm_hold;
    logic        mon_en;
    logic [4:0]  wr_key;
    logic [1:0]  wr_sel;
    logic        wr_cm;
    logic [16:0] upper;
    logic        flt_busy;
    logic        wd_run;
    logic        wr_take;

    // Field split of the write data
    assign wr_sel   = svc_wdata[SEL_MSB:SEL_LSB];
    assign wr_key   = svc_wdata[KEY_MSB:KEY_LSB];
    assign wr_cm    = svc_wdata[CMEN_BIT];
    assign upper    = UPPER_BASE << st_r.sel;
    assign flt_busy = (st_r.flt != FLT_IDLE);
    assign wd_run   = st_r.started && st_r.wd_en && !halt_mode && !idle_mode;
    assign wr_take  = svc_wr && st_r.started && st_r.wd_en && !flt_busy;
    assign mon_en   = st_r.started && st_r.wd_en && st_r.cm_en;

    // Monitor keeps running in HALT and IDLE, only the enable gates it
    wcm_clk_mon #(
        .CM_LIMIT (CM_LIMIT)
    ) u_clk_mon (
        .core_clk     (core_clk),
        .nrst         (nrst),
        .instr_clk_in (instr_clk_in),
        .mon_en       (mon_en),
        .cm_hold      (cm_hold)
    );

    // Service check, window count and fault sequencing
    always_comb begin
        logic err;
        logic restart;
        err     = 1'b0;
        restart = 1'b0;
        st_nxt  = st_r;

        // Pin sense: a level counts once the second and third stages agree
        st_nxt.pin_s1 = fault_pin_in;
        st_nxt.pin_s2 = st_r.pin_s1;
        st_nxt.pin_s3 = st_r.pin_s2;
        if (st_r.pin_s2 == st_r.pin_s3) begin
            st_nxt.pin_lvl = st_r.pin_s3;
        end

        // Option bit is caught once, on the first edge after reset release
        if (!st_r.started) begin
            st_nxt.started = 1'b1;
            st_nxt.wd_en   = !wd_option_bit2;
        end

        st_nxt.idle_d = idle_mode;
        st_nxt.halt_d = halt_mode;
        st_nxt.boot_d = boot_rom_active;

        // Register writes
        if (wr_take) begin
            if (!st_r.first_done) begin
                if (wr_key == KEY_VALUE) begin
                    st_nxt.sel        = wr_sel;
                    st_nxt.cm_en      = wr_cm;
                    st_nxt.first_done = 1'b1;
                    restart           = 1'b1;
                end else begin
                    err = 1'b1;
                end
            end else if (wr_key != KEY_VALUE || wr_sel != st_r.sel || wr_cm != st_r.cm_en) begin
                err = 1'b1;
            end else if (st_r.lower_en && st_r.cnt < LOWER_BOUND && !boot_rom_active) begin
                err = 1'b1;
            end else begin
                restart = 1'b1;
            end
        end

        // Hardware services: boot ROM entry, leaving IDLE, leaving HALT
        if (st_r.wd_en && boot_rom_active && !st_r.boot_d) begin
            restart = 1'b1;
        end
        if (st_r.wd_en && st_r.idle_d && !idle_mode) begin
            restart = 1'b1;
        end
        if (st_r.wd_en && st_r.halt_d && !halt_mode) begin
            restart = 1'b1;
        end

        // Window counter; frozen while a fault is in progress
        if (wd_run && !flt_busy && idle_tick) begin
            if (st_r.cnt + 17'h00001 >= upper) begin
                err = 1'b1;
            end else begin
                st_nxt.cnt = st_r.cnt + 17'h00001;
            end
        end

        // Fault pin sequencer
        unique case (st_r.flt)
            FLT_IDLE: begin
                if (err) begin
                    st_nxt.flt = FLT_WAIT_LOW;
                end
            end
            FLT_WAIT_LOW: begin
                if (!st_r.pin_lvl) begin
                    st_nxt.flt      = FLT_HOLD;
                    st_nxt.hold_cnt = 5'h00;
                end
            end
            FLT_HOLD: begin
                st_nxt.hold_cnt = st_r.hold_cnt + 5'h01;
                if (st_r.hold_cnt == RELEASE_CYC - 5'h01) begin
                    st_nxt.flt = FLT_WAIT_HIGH;
                end
            end
            FLT_WAIT_HIGH: begin
                if (st_r.pin_lvl) begin
                    st_nxt.flt = FLT_IDLE;
                    restart    = 1'b1;
                end
            end
        endcase

        // Lower bound applies only once software has made its first service
        if (restart) begin
            st_nxt.cnt      = 17'h00000;
            st_nxt.lower_en = st_nxt.first_done && !boot_rom_active;
        end

        // Open drain: drive low or release to the pull-up
        st_nxt.drive = st_nxt.wd_en && (st_nxt.flt == FLT_WAIT_LOW
                                        || st_nxt.flt == FLT_HOLD || cm_hold);
        st_nxt.out_n = !st_nxt.drive;

        // Key field always reads back as zero
        st_nxt.rdata = {st_nxt.sel, 5'h00, st_nxt.cm_en};
    end

    // Reset arms the longest window with the monitor enabled, detectors idle
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            st_r         <= '0;
            st_r.sel     <= SEL_RESET;
            st_r.cm_en   <= CMEN_RESET;
            st_r.pin_s1  <= 1'b1;
            st_r.pin_s2  <= 1'b1;
            st_r.pin_s3  <= 1'b1;
            st_r.pin_lvl <= 1'b1;
            st_r.out_n   <= 1'b1;
            st_r.rdata   <= {SEL_RESET, 5'h00, CMEN_RESET};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign svc_rdata   = st_r.rdata;
    assign fault_out_n = st_r.out_n;
    assign fault_oe    = st_r.drive;

    // Checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);

    sequence s_bad_key_write;
        svc_wr && st_r.started && st_r.wd_en && !flt_busy && wr_key != KEY_VALUE;
    endsequence

    sequence s_hold_enter;
        st_r.flt == FLT_WAIT_LOW ##1 st_r.flt == FLT_HOLD;
    endsequence

    sequence s_early_write;
        svc_wr && st_r.wd_en && !flt_busy && st_r.first_done && st_r.lower_en
        && st_r.cnt < LOWER_BOUND && !boot_rom_active && wr_key == KEY_VALUE
        && wr_sel == st_r.sel && wr_cm == st_r.cm_en;
    endsequence

    AST_BAD_KEY: assert property (s_bad_key_write |=> st_r.flt == FLT_WAIT_LOW ##1 fault_oe)
        else $error("wrong key did not raise a fault");

    AST_EARLY: assert property (s_early_write |=> st_r.flt == FLT_WAIT_LOW)
        else $error("service before lower bound not flagged");

    AST_HOLD_LEN: assert property (s_hold_enter |-> (st_r.flt == FLT_HOLD)[*8] ##8
        st_r.flt == FLT_HOLD ##1 (st_r.flt == FLT_WAIT_HIGH && !fault_oe || cm_hold))
        else $error("fault hold length wrong");

    AST_RESTART: assert property (st_r.flt == FLT_WAIT_HIGH && st_r.pin_lvl
        |=> st_r.cnt == 17'h00000 && st_r.flt == FLT_IDLE)
        else $error("window not restarted on pin high");

    AST_IGNORE: assert property (svc_wr && st_r.flt == FLT_HOLD
        |=> $stable(st_r.sel) && $stable(st_r.cm_en) && st_r.flt != FLT_WAIT_LOW)
        else $error("write during fault was not ignored");

    AST_TIMEOUT: assert property (wd_run && !flt_busy && idle_tick && !svc_wr
        && st_r.cnt == upper - 17'h00001 |=> st_r.flt == FLT_WAIT_LOW)
        else $error("upper bound expiry not flagged");

    AST_FIRST_LOAD: assert property (svc_wr && st_r.started && st_r.wd_en && !flt_busy
        && !st_r.first_done && wr_key == KEY_VALUE
        |=> st_r.sel == $past(wr_sel) && st_r.cm_en == $past(wr_cm) && st_r.first_done)
        else $error("first keyed write did not load");

    AST_READ_KEY: assert property (svc_rdata[KEY_MSB:KEY_LSB] == 5'h00)
        else $error("key readable");

    AST_DISABLED: assert property (st_r.started && !st_r.wd_en |-> !fault_oe)
        else $error("disabled watchdog drove the pin");

    AST_HALT_FREEZE: assert property (halt_mode && !flt_busy && !boot_rom_active
        ##1 halt_mode && !boot_rom_active && !svc_wr |-> $stable(st_r.cnt))
        else $error("window counted during halt");

    // Leaving IDLE clears the window count on the next edge
    AST_IDLE_EXIT: assert property (st_r.wd_en && st_r.idle_d && !idle_mode
        |=> st_r.cnt == 17'h00000)
        else $error("idle exit did not service");

    // Boot ROM entry services at once and keeps the lower bound off
    AST_BOOT_SVC: assert property (st_r.wd_en && boot_rom_active && !st_r.boot_d
        |=> st_r.cnt == 17'h00000 && !st_r.lower_en)
        else $error("boot entry did not service");

    // Fresh out of reset the longest window is armed and the pin released
    AST_RESET_ARM: assert property (!st_r.started
        |-> svc_rdata == {SEL_RESET, 5'h00, CMEN_RESET} && !fault_oe)
        else $error("reset state not armed");

    // Open drain: the output value is low exactly while the pin is driven
    AST_OD_PAIR: assert property (fault_out_n == !fault_oe)
        else $error("fault output level and enable disagree");

endmodule
`default_nettype wire

// ### wcm_pin_model.sv
// Fault pin model: weak pull-up, open-drain pull by the watchdog, optional outside pull
`timescale 1ns/1ns
`default_nettype none
module wcm_pin_model (
    input  wire logic fault_oe,
    input  wire logic fault_out_n,
    input  wire logic ext_low,
    output var  logic pin_level
);
    // Low when driven or pulled outside, else the pull-up wins
    always_comb begin
        pin_level = ((fault_oe && !fault_out_n) || ext_low) ? 1'b0 : 1'b1;
    end
endmodule
`default_nettype wire

// ### tb_top.sv
// Self-checking bench for the windowed watchdog and clock monitor
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    import wcm_pkg::*;
    logic       core_clk, nrst, svc_wr, idle_tick, opt2, halt_mode, idle_mode;
    logic       boot_rom, iclk, clk_run, ext_low, fault_out_n, fault_oe, pin, seen;
    logic [7:0] svc_wdata, svc_rdata;
    int         fail_count, num_checks, n;
    // First write and the read-back it should give
    logic [15:0] rows [8] = '{16'h1800, 16'h1901, 16'h5840, 16'h5941,
                              16'h9880, 16'h9981, 16'hd8c0, 16'hd9c1};
    // Later writes after sel 00 cm 0: top bit says a fault is due
    logic [8:0]  svcs [4] = '{9'h018, 9'h11a, 9'h158, 9'h119};

    wcm_watchdog #(.CM_LIMIT(16'h0040)) uut (
        .core_clk(core_clk), .nrst(nrst), .svc_wr(svc_wr), .svc_wdata(svc_wdata),
        .svc_rdata(svc_rdata), .idle_tick(idle_tick), .wd_option_bit2(opt2),
        .halt_mode(halt_mode), .idle_mode(idle_mode), .boot_rom_active(boot_rom),
        .instr_clk_in(iclk), .fault_pin_in(pin), .fault_out_n(fault_out_n),
        .fault_oe(fault_oe));
    wcm_pin_model pin_m (.fault_oe(fault_oe), .fault_out_n(fault_out_n),
        .ext_low(ext_low), .pin_level(pin));

    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    // Instruction clock, well above the monitor limit while it runs
    always begin
        #100;
        if (clk_run) iclk = ~iclk;
    end

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, got, exp);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic rst();
        nrst = 1'b0;
        repeat (12) @(negedge core_clk);
        nrst = 1'b1;
        repeat (2) @(negedge core_clk);
    endtask
    task automatic wr(input logic [7:0] d);
        svc_wr = 1'b1;
        svc_wdata = d;
        @(negedge core_clk);
        svc_wr = 1'b0;
    endtask
    // Runs cycles with or without idle ticks, noting any fault drive
    task automatic run(input int cyc, input logic t);
        seen = 1'b0;
        idle_tick = t;
        repeat (cyc) begin
            @(negedge core_clk);
            seen |= fault_oe;
        end
        idle_tick = 1'b0;
    endtask
    // Expects a fault within lim cycles, a bounded hold, then release
    task automatic fault_seq(input int lim);
        n = 0;
        while (fault_oe !== 1'b1 && n < lim) begin
            @(negedge core_clk);
            n++;
        end
        check({7'h0, fault_oe}, 8'h01);
        check({7'h0, fault_out_n}, 8'h00);
        n = 0;
        while (fault_oe === 1'b1 && n < 100) begin
            @(negedge core_clk);
            n++;
        end
        check({7'h0, n >= 17 && n <= 38}, 8'h01);
        idle_tick = 1'b0;
        repeat (6) @(negedge core_clk);
        check({7'h0, fault_out_n}, 8'h01);
    endtask

    initial begin
        nrst = 1'b0; svc_wr = 1'b0; svc_wdata = 8'h00; idle_tick = 1'b0; opt2 = 1'b0;
        halt_mode = 1'b0; idle_mode = 1'b0; boot_rom = 1'b0; iclk = 1'b0;
        clk_run = 1'b1; ext_low = 1'b0; fail_count = 0; num_checks = 0;
        // Every window select and monitor choice as the first write
        for (int i = 0; i < 8; i++) begin
            rst();
            check(svc_rdata, 8'hc1);
            check({7'h0, fault_oe}, 8'h00);
            wr(rows[i][15:8]);
            @(negedge core_clk);
            check(svc_rdata, rows[i][7:0]);
            $display("row %0d done", i);
        end
        // Upper bound of the shortest window
        rst();
        wr(8'h18);
        run(8190, 1'b1);
        check({7'h0, seen}, 8'h00);
        idle_tick = 1'b1;
        fault_seq(6);
        // Window restarted at pin high, so an instant service is too early
        wr(8'h18);
        fault_seq(4);
        $display("timeout and lower bound done");
        // Valid service and each kind of field mismatch
        for (int i = 0; i < 4; i++) begin
            run(2049, 1'b1);
            wr(svcs[i][7:0]);
            if (svcs[i][8]) begin
                fault_seq(4);
            end else begin
                run(4, 1'b0);
                check({7'h0, seen}, 8'h00);
            end
        end
        $display("service table done");
        // Ticks are ignored in idle, and leaving idle restarts the window
        run(7000, 1'b1);
        idle_mode = 1'b1;
        run(3000, 1'b1);
        idle_mode = 1'b0;
        run(7000, 1'b1);
        check({7'h0, seen}, 8'h00);
        // Boot ROM entry services at once with the lower bound off
        boot_rom = 1'b1;
        run(3, 1'b0);
        wr(8'h18);
        run(4, 1'b0);
        check({7'h0, seen}, 8'h00);
        boot_rom = 1'b0;
        $display("idle and boot done");
        // Clock monitor is on after reset and catches a stopped clock
        rst();
        clk_run = 1'b0;
        run(80, 1'b0);
        check({7'h0, fault_oe}, 8'h01);
        run(100, 1'b0);
        check({7'h0, fault_oe}, 8'h01);
        clk_run = 1'b1;
        run(30, 1'b0);
        check({7'h0, fault_oe}, 8'h00);
        $display("clock monitor done");
        // Bad first key, then the pin held low outside: the fault waits for it
        rst();
        wr(8'h00);
        ext_low = 1'b1;
        run(40, 1'b0);
        check({7'h0, seen}, 8'h01);
        check({7'h0, fault_oe}, 8'h00);
        wr(8'h18);
        @(negedge core_clk);
        check(svc_rdata, 8'hc1);
        ext_low = 1'b0;
        repeat (8) @(negedge core_clk);
        wr(8'h18);
        @(negedge core_clk);
        check(svc_rdata, 8'h00);
        $display("pin held low done");
        // Option bit set: nothing ever drives the pin
        opt2 = 1'b1;
        rst();
        wr(8'h1a);
        clk_run = 1'b0;
        run(200, 1'b0);
        check({7'h0, seen}, 8'h00);
        clk_run = 1'b1;
        $display("option done");
        stop_test();
    end

    // Watchdog on the whole run
    initial begin
        #4000000;
        fail_count++;
        stop_test();
    end
endmodule
`default_nettype wire
